// >>> hdl/issc_pkg.sv
// package: constants and types of the instruction set state control block
package issc_pkg;
  // ---------------------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  REG_STATE    = 8'h00;   // ro: state bits, mode, non-secure flag
  localparam logic [7:0]  REG_BRANCH   = 8'h04;   // wo: state-changing branch command
  localparam logic [7:0]  REG_PSR      = 8'h08;   // rw: mode and non-secure flag
  localparam logic [7:0]  REG_DECODE   = 8'h0C;   // ro: last decode result

  // field positions
  localparam int unsigned F_TBIT       = 0;       // low state bit
  localparam int unsigned F_JBIT       = 1;       // high state bit
  localparam int unsigned F_MODE_LO    = 4;       // mode field, 5 bits
  localparam int unsigned F_NONSEC     = 12;      // non-secure flag
  localparam int unsigned F_LEN_LO     = 0;       // decode: length in bytes, 3 bits
  localparam int unsigned F_FAULT      = 4;       // decode: alignment fault
  localparam int unsigned F_TRAP       = 5;       // decode: handed to software
  localparam int unsigned F_DYN        = 6;       // decode: dynamic-code variant

  // reset values
  localparam logic [1:0]  RST_STATE    = 2'h0;    // both state bits clear
  localparam logic [4:0]  MODE_SVC     = 5'h13;   // privileged supervisor mode
  localparam logic        RST_NONSEC   = 1'b0;    // secure after reset

  // decode constants
  localparam logic [2:0]  LEN_BYTE     = 3'h1;
  localparam logic [2:0]  LEN_HALF     = 3'h2;
  localparam logic [2:0]  LEN_THREE    = 3'h3;
  localparam logic [2:0]  LEN_WORD     = 3'h4;
  localparam logic [7:0]  BC_PUSH1     = 8'h10;   // bytecode with one operand byte
  localparam logic [7:0]  BC_PUSH2     = 8'h11;   // bytecode with two operand bytes
  localparam logic [7:0]  BC_HANDLER   = 8'hCB;   // this opcode and above go to software
  localparam logic [4:0]  HW_WIDE_MIN  = 5'h1D;   // compact halfword prefix of a 32-bit op

  typedef enum logic [1:0] {
    ISA_WIDE,
    ISA_COMPACT,
    ISA_BYTECODE,
    ISA_DYNCODE
  } issc_isa_e;
endpackage

// >>> hdl/issc_len_decode.sv
// length, alignment and hand-off decode of one fetched instruction
`timescale 1ns/1ps
module issc_len_decode (
  input  wire issc_pkg::issc_isa_e isa,        // current instruction set state
  input  wire logic [1:0]          addrLow,    // low fetch address bits
  input  wire logic [31:0]         word,       // instruction bytes from the fetch address
  output logic [2:0]               len,        // instruction length in bytes
  output logic                     alignFault, // fetch address misaligned for the state
  output logic                     trap,       // bytecode handed to a software handler
  output logic                     dynCode     // dynamic-code variant of compact decode
);
  logic [7:0] opcode;
  logic       isWide16;

  assign opcode   = word[7:0];
  assign isWide16 = word[15:11] >= issc_pkg::HW_WIDE_MIN;

  // per-state decode; unused states cannot exist, so no default
  always_comb begin
    len        = issc_pkg::LEN_WORD;
    alignFault = 1'b0;
    trap       = 1'b0;
    dynCode    = 1'b0;
    unique case (isa)
      issc_pkg::ISA_WIDE: begin
        len        = issc_pkg::LEN_WORD;
        alignFault = addrLow != 2'h0;
      end
      issc_pkg::ISA_COMPACT: begin
        len        = isWide16 ? issc_pkg::LEN_WORD : issc_pkg::LEN_HALF;
        alignFault = addrLow[0];
      end
      issc_pkg::ISA_BYTECODE: begin
        if (opcode == issc_pkg::BC_PUSH1) begin
          len = issc_pkg::LEN_HALF;
        end else if (opcode == issc_pkg::BC_PUSH2) begin
          len = issc_pkg::LEN_THREE;
        end else begin
          len = issc_pkg::LEN_BYTE;
        end
        trap = opcode >= issc_pkg::BC_HANDLER;
      end
      issc_pkg::ISA_DYNCODE: begin
        len        = isWide16 ? issc_pkg::LEN_WORD : issc_pkg::LEN_HALF;
        alignFault = addrLow[0];
        dynCode    = 1'b1;
      end
    endcase
  end
endmodule // issc_len_decode

// >>> hdl/issc_state_ctrl.sv
// instruction set state control: state bits, boot state and fetch decode
// Function
// - two status bits select the state
// - wide state: 32-bit word-aligned instructions only
// - compact state: 16/32-bit, halfword aligned
// - bytecode state: variable length, any byte
// - dynamic-code state: modified compact instruction set
// - most bytecodes in hardware, rest to software
// - reset: supervisor mode, secure, flag cleared
// - wide/compact switch keeps mode and registers
`timescale 1ns/1ps
module issc_state_ctrl (
  input  wire  logic        clk,           // 100 MHz processor clock
  input  wire  logic        srst,          // synchronous reset, active high
  input  wire  logic [7:0]  regAddr,       // register byte address
  input  wire  logic [31:0] regWdata,      // register write data
  input  wire  logic        regWr,         // register write strobe
  input  wire  logic        regRd,         // register read strobe
  output logic [31:0]       regRdata,      // read data, cycle after the strobe
  input  wire  logic        branchXchg,    // state-changing branch retires
  input  wire  logic [1:0]  branchState,   // target state bits of the branch
  input  wire  logic        excEntry,      // exception taken
  input  wire  logic [4:0]  excMode,       // mode entered by the exception
  input  wire  logic        excCompact,    // exceptions enter the compact state
  input  wire  logic        excReturn,     // exception return
  input  wire  logic [1:0]  savedState,    // state bits restored on return
  input  wire  logic [4:0]  savedMode,     // mode restored on return
  input  wire  logic        fetchValid,    // fetched instruction present
  input  wire  logic [31:0] fetchAddr,     // fetch address
  input  wire  logic [31:0] fetchWord,     // bytes from the fetch address upward
  output logic [1:0]        isaBits,       // state bits, high then low
  output logic [4:0]        procMode,      // processor mode
  output logic              nonsecureFlag, // non-secure flag
  output logic              instrValid,    // decode result valid, one cycle
  output logic [2:0]        instrLen,      // instruction length in bytes
  output logic              alignFault,    // misaligned fetch for the state
  output logic              handlerTrap,   // bytecode to software handler
  output logic              dynCode        // dynamic-code decode in use
);
  // ---------------------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------------------
  logic [1:0]          state_q;
  logic [1:0]          state_d;
  logic [4:0]          mode_q;
  logic [4:0]          mode_d;
  logic                nonsec_q;
  issc_pkg::issc_isa_e isa;
  logic                swBranch;
  logic                psrWr;
  logic [2:0]          decLen;
  logic                decFault;
  logic                decTrap;
  logic                decDyn;

  assign swBranch = regWr && regAddr == issc_pkg::REG_BRANCH;
  assign psrWr    = regWr && regAddr == issc_pkg::REG_PSR;

  always_comb begin
    unique case (state_q)
      2'h0: isa = issc_pkg::ISA_WIDE;
      2'h1: isa = issc_pkg::ISA_COMPACT;
      2'h2: isa = issc_pkg::ISA_BYTECODE;
      2'h3: isa = issc_pkg::ISA_DYNCODE;
    endcase
  end

  // next state: exception entry wins over return, return over branches
  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    if (excEntry) begin
      state_d = excCompact ? 2'h1 : issc_pkg::RST_STATE;
      mode_d  = excMode;
    end else if (excReturn) begin
      state_d = savedState;
      mode_d  = savedMode;
    end else if (branchXchg) begin
      state_d = branchState;
    end else if (swBranch) begin
      state_d = regWdata[issc_pkg::F_JBIT:issc_pkg::F_TBIT];
    end else if (psrWr) begin
      mode_d  = regWdata[issc_pkg::F_MODE_LO +: 5];
    end
  end

  // state bits; register writes to the status word never touch them
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= issc_pkg::RST_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // mode and security flag
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q   <= issc_pkg::MODE_SVC;
      nonsec_q <= issc_pkg::RST_NONSEC;
    end else begin
      mode_q <= mode_d;
      if (psrWr && !excEntry && !excReturn && !branchXchg) begin
        nonsec_q <= regWdata[issc_pkg::F_NONSEC];
      end
    end
  end

  assign isaBits       = state_q;
  assign procMode      = mode_q;
  assign nonsecureFlag = nonsec_q;

  // ---------------------------------------------------------------------------
  // fetch decode
  // ---------------------------------------------------------------------------
  issc_len_decode u_dec (
    .isa        (isa),
    .addrLow    (fetchAddr[1:0]),
    .word       (fetchWord),
    .len        (decLen),
    .alignFault (decFault),
    .trap       (decTrap),
    .dynCode    (decDyn)
  );

  // results registered so the pipeline sees a clean one-cycle pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      instrValid  <= 1'b0;
      instrLen    <= issc_pkg::LEN_WORD;
      alignFault  <= 1'b0;
      handlerTrap <= 1'b0;
      dynCode     <= 1'b0;
    end else begin
      instrValid <= fetchValid;
      if (fetchValid) begin
        instrLen    <= decLen;
        alignFault  <= decFault;
        handlerTrap <= decTrap;
        dynCode     <= decDyn;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------------------
  // data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= 32'h0000_0000;
      if (regRd) begin
        unique case (regAddr)
          issc_pkg::REG_STATE, issc_pkg::REG_PSR: begin
            regRdata[issc_pkg::F_JBIT:issc_pkg::F_TBIT] <= state_q;
            regRdata[issc_pkg::F_MODE_LO +: 5]           <= mode_q;
            regRdata[issc_pkg::F_NONSEC]                 <= nonsec_q;
          end
          issc_pkg::REG_DECODE: begin
            regRdata[issc_pkg::F_LEN_LO +: 3] <= instrLen;
            regRdata[issc_pkg::F_FAULT]       <= alignFault;
            regRdata[issc_pkg::F_TRAP]        <= handlerTrap;
            regRdata[issc_pkg::F_DYN]         <= dynCode;
          end
          default: regRdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  sequence s_fetchIn(logic [1:0] st);
    fetchValid && state_q == st;
  endsequence

  sequence s_noEvent;
    !excEntry && !excReturn && !branchXchg && !swBranch;
  endsequence

  a_reset_boot: assert property (@(posedge clk)
    srst |=> procMode == issc_pkg::MODE_SVC && !nonsecureFlag)
    else $error("boot mode or security wrong");
  a_reset_wide: assert property (@(posedge clk)
    srst |=> isaBits == 2'h0)
    else $error("state bits not cleared by reset");
  a_state_hold: assert property (@(posedge clk) disable iff (srst)
    s_noEvent |=> $stable(isaBits))
    else $error("state bits changed without branch or exception");
  a_branch_mode: assert property (@(posedge clk) disable iff (srst)
    (branchXchg && !excEntry && !excReturn) |=> isaBits == $past(branchState) && $stable(procMode))
    else $error("branch did not keep mode or set target");
  a_wide_word: assert property (@(posedge clk) disable iff (srst)
    s_fetchIn(2'h0) |=> instrValid && instrLen == 3'h4 && alignFault == ($past(fetchAddr[1:0]) != 2'h0))
    else $error("wide decode length or alignment wrong");
  a_compact_half: assert property (@(posedge clk) disable iff (srst)
    s_fetchIn(2'h1) |=> alignFault == $past(fetchAddr[0]) && (instrLen == 3'h2 || instrLen == 3'h4))
    else $error("compact decode wrong");
  a_byte_any: assert property (@(posedge clk) disable iff (srst)
    s_fetchIn(2'h2) |=> !alignFault && instrLen != 3'h4 && !dynCode)
    else $error("bytecode decode wrong");
  a_dyn_variant: assert property (@(posedge clk) disable iff (srst)
    s_fetchIn(2'h3) |=> dynCode && alignFault == $past(fetchAddr[0]))
    else $error("dynamic-code decode wrong");
  a_bc_trap: assert property (@(posedge clk) disable iff (srst)
    s_fetchIn(2'h2) |=> handlerTrap == ($past(fetchWord[7:0]) >= 8'hCB))
    else $error("bytecode hand-off wrong");
  a_exc_entry: assert property (@(posedge clk) disable iff (srst)
    excEntry |=> procMode == $past(excMode) && isaBits == {1'b0, $past(excCompact)})
    else $error("exception entry state wrong");
  a_rd_window: assert property (@(posedge clk) disable iff (srst)
    !regRd |=> regRdata == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule // issc_state_ctrl

// >>> verif/instruction_set_state_control_tb_top.sv
// testbench: directed scenarios for the instruction set state control block
`timescale 1ns/1ps
module instruction_set_state_control_tb_top;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic        clk;
  logic        srst;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        branchXchg;
  logic [1:0]  branchState;
  logic        excEntry;
  logic [4:0]  excMode;
  logic        excCompact;
  logic        excReturn;
  logic [1:0]  savedState;
  logic [4:0]  savedMode;
  logic        fetchValid;
  logic [31:0] fetchAddr;
  logic [31:0] fetchWord;
  logic [1:0]  isaBits;
  logic [4:0]  procMode;
  logic        nonsecureFlag;
  logic        instrValid;
  logic [2:0]  instrLen;
  logic        alignFault;
  logic        handlerTrap;
  logic        dynCode;
  int          errors;
  int          num_checks;

  issc_state_ctrl u_issc_state_ctrl (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .branchXchg(branchXchg), .branchState(branchState), .excEntry(excEntry),
    .excMode(excMode), .excCompact(excCompact), .excReturn(excReturn), .savedState(savedState),
    .savedMode(savedMode), .fetchValid(fetchValid), .fetchAddr(fetchAddr), .fetchWord(fetchWord),
    .isaBits(isaBits), .procMode(procMode), .nonsecureFlag(nonsecureFlag), .instrValid(instrValid),
    .instrLen(instrLen), .alignFault(alignFault), .handlerTrap(handlerTrap), .dynCode(dynCode)
  );

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // status word as the state register packs it
  function automatic logic [31:0] stat(input logic nonsec, input logic [4:0] mode, input logic [1:0] bits);
    return {19'h0, nonsec, 3'h0, mode, 2'h0, bits};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, exp, msg);
  endtask

  // one-cycle pulse on any mix of the three event inputs; their data change on the same edge
  task automatic ev(input logic e, input logic r, input logic b, input logic [1:0] tgt, input logic [4:0] eMode,
                    input logic cmp, input logic [1:0] sState, input logic [4:0] sMode);
    @(posedge clk);
    excEntry    <= e;
    excReturn   <= r;
    branchXchg  <= b;
    branchState <= tgt;
    excMode     <= eMode;
    excCompact  <= cmp;
    savedState  <= sState;
    savedMode   <= sMode;
    @(posedge clk);
    {excEntry, excReturn, branchXchg} <= 3'h0;
    #1;
  endtask

  task automatic fetch(input logic [31:0] a, input logic [31:0] w, input logic [5:0] exp);
    @(posedge clk);
    fetchValid <= 1'b1;
    fetchAddr  <= a;
    fetchWord  <= w;
    @(posedge clk);
    fetchValid <= 1'b0;
    #1;
    chk({instrValid, instrLen, alignFault, handlerTrap, dynCode}, {1'b1, exp[5:3], exp[2:0]}, "decode");
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk({isaBits, procMode, nonsecureFlag}, {2'h0, issc_pkg::MODE_SVC, 1'b0}, "boot");
    rd(issc_pkg::REG_STATE, stat(1'b0, 5'h13, 2'h0), "boot status");
  endtask

  // every code via the branch register, then code 1 via the branch port
  task automatic t_states();
    for (int s = 0; s < 4; s++) begin
      wr(issc_pkg::REG_BRANCH, 32'(s));
      chk(32'({isaBits, procMode}), 32'({s[1:0], 5'h13}), "branch state");
    end
    ev(1'b0, 1'b0, 1'b1, 2'h1, 5'h00, 1'b0, 2'h0, 5'h00);
    chk(32'({isaBits, procMode}), 32'h0000_0033, "branch port");
    wr(issc_pkg::REG_STATE, 32'h0000_0002);
    rd(issc_pkg::REG_STATE, stat(1'b0, 5'h13, 2'h1), "ro state");
  endtask

  // fields: len, fault, trap, dyn
  task automatic t_decode();
    wr(issc_pkg::REG_BRANCH, 32'h0000_0000);
    fetch(32'h0000_0100, 32'h0000_4000, 6'b100_000);
    fetch(32'h0000_0102, 32'h0000_4000, 6'b100_100);
    wr(issc_pkg::REG_BRANCH, 32'h0000_0001);
    fetch(32'h0000_0102, 32'h0000_4000, 6'b010_000);
    fetch(32'h0000_0106, 32'h0000_E800, 6'b100_000);
    fetch(32'h0000_0101, 32'h0000_4000, 6'b010_100);
    wr(issc_pkg::REG_BRANCH, 32'h0000_0002);
    fetch(32'h0000_0103, 32'h0000_0010, 6'b010_000);
    fetch(32'h0000_0101, 32'h0000_0011, 6'b011_000);
    fetch(32'h0000_0102, 32'h0000_00CA, 6'b001_000);
    fetch(32'h0000_0102, 32'h0000_00CB, 6'b001_010);
    rd(issc_pkg::REG_DECODE, 32'h0000_0021, "decode reg");
    wr(issc_pkg::REG_BRANCH, 32'h0000_0003);
    fetch(32'h0000_0104, 32'h0000_F000, 6'b100_001);
    fetch(32'h0000_0105, 32'h0000_4000, 6'b010_101);
  endtask

  // exceptions, priority, mode register and unmapped place
  task automatic t_except();
    ev(1'b1, 1'b0, 1'b0, 2'h0, 5'h17, 1'b1, 2'h0, 5'h00);
    chk(32'({isaBits, procMode}), 32'({2'h1, 5'h17}), "exc entry");
    ev(1'b0, 1'b1, 1'b1, 2'h2, 5'h17, 1'b0, 2'h3, 5'h10);
    chk(32'({isaBits, procMode}), 32'({2'h3, 5'h10}), "exc return wins");
    ev(1'b1, 1'b1, 1'b0, 2'h2, 5'h17, 1'b0, 2'h3, 5'h10);
    chk(32'({isaBits, procMode}), 32'({2'h0, 5'h17}), "exc entry wins");
    wr(issc_pkg::REG_PSR, 32'h0000_11F3);
    rd(issc_pkg::REG_PSR, stat(1'b1, 5'h1F, 2'h0), "psr write");
    chk(32'(nonsecureFlag), 32'h0000_0001, "ns flag");
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000, "unmapped");
  endtask

  // second reset in mid-run brings the boot state back
  task automatic t_rereset();
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    chk({isaBits, procMode, nonsecureFlag}, {2'h0, 5'h13, 1'b0}, "reboot");
    chk(32'({instrValid, instrLen}), 32'h0000_0004, "reboot decode");
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    errors = 0;
    num_checks = 0;
    {srst, regWr, regRd, branchXchg, excEntry, excReturn, fetchValid, excCompact} = 8'h80;
    {regAddr, regWdata, fetchAddr, fetchWord} = '0;
    {branchState, excMode, savedState, savedMode} = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1;
    t_reset();
    t_states();
    t_decode();
    t_except();
    t_rereset();
    final_report();
  end

  // watchdog against a hang
  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule // instruction_set_state_control_tb_top
